//--- dsc_defs.svh
// Register offsets, field positions, reset values and codes for the channel control block
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// Register indices; the byte address is four times the index
`define DSC_IDX_MAIN 4'h0
`define DSC_IDX_STAT 4'h1
`define DSC_IDX_SRC 4'h2
`define DSC_IDX_DST 4'h3
`define DSC_IDX_CNT 4'h4

// Main control bits
`define DSC_MAIN_EN 7
`define DSC_MAIN_RPT 5
`define DSC_MAIN_SWREQ 4
`define DSC_MAIN_SINGLE 2
`define DSC_MAIN_BURST 0

// Status and interrupt control bits
`define DSC_STAT_ACTIVE 7
`define DSC_STAT_WAIT 6
`define DSC_STAT_FAULT 5
`define DSC_STAT_DONE 4

// Pointer mode codes
`define DSC_MODE_FIXED 3'h0
`define DSC_MODE_INC 3'h1
`define DSC_MODE_MASK 3'h4
`define DSC_MODE_OR 3'h5
`define DSC_MODE_TWO 3'h6

`define DSC_RELOAD_NONE 2'h0
`define DSC_RELOAD_BLOCK 2'h1
`define DSC_RELOAD_BURST 2'h2
`define DSC_RELOAD_TRANS 2'h3

`define DSC_RST_BYTE 8'h00
`define DSC_RST_COUNT 8'h01
`define DSC_BYTE_TIME_NS 10
`define DSC_BYTE_CYC ((`DSC_BYTE_TIME_NS + 9) / 10)

`endif

//--- dsc_pkg.sv
// Types for the channel control block
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_IDLE,
    DSC_WAIT,
    DSC_BURST,
    DSC_GAP
  } dsc_state_t;

  typedef struct packed {
    logic [1:0] reload;
    logic [2:0] mode;
  } dsc_ptr_ctl_t;

  typedef struct packed {
    logic reload_now;
    logic step_now;
  } dsc_ptr_evt_t;
endpackage

//--- dsc_channel.sv
// Standard channel control, status and pointer steering behind an Avalon-MM slave
//
// How it works
// - Single-shot does one burst per trigger; writes ignored while enabled.
// - Burst select 0 is one byte, 1 two bytes; frozen while busy.
// - Active flag reads one once a transaction begins.
// - Active flag clears on disable, done flag set or fault flag set.
// - Waiting flag is one while the first block after enable is pending; clears on start or abort.
// - Detected error sets fault flag; request raised when fault level nonzero.
// - Fault flag clears only by software writing one to it.
// - Done flag set after block when repeat is off; repeat mode never sets it; request if level nonzero.
// - Done flag clears only by software writing one to it.
// - Fault level in bits 3:2 gates the fault request.
// - Done level in bits 1:0 gates the done request.
// - Source reload selects none, block, burst or transaction; frozen while busy.
// - Source mode 000 fixed, 001 increment, others reserved; frozen while busy.
// - Destination reload selects none, block, burst or transaction; frozen while busy.
// - Enable starts channel, self clears at end; clearing aborts between bursts.
// - Software request acts as trigger when enabled; clears when transfer starts.
// - Destination mode fixed, increment, or three search codes; rest reserved.
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dsc_defs.svh"
`default_nettype none

module dsc_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic trig_in,
  input wire logic err_in,
  input wire logic match_in,
  output logic byte_req,
  output dsc_pkg::dsc_ptr_evt_t src_evt,
  output dsc_pkg::dsc_ptr_evt_t dst_evt,
  output dsc_pkg::dsc_ptr_ctl_t src_ctl,
  output dsc_pkg::dsc_ptr_ctl_t dst_ctl,
  output logic fault_irq,
  output logic [1:0] fault_irq_pri,
  output logic done_irq,
  output logic [1:0] done_irq_pri
);

  // ==========================================================
  // Input synchronisers
  logic trig_m_q, trig_s_q, err_m_q, err_s_q, match_m_q, match_s_q, trig_prev_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      err_m_q <= 1'b0;
      err_s_q <= 1'b0;
      match_m_q <= 1'b0;
      match_s_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_m_q <= trig_in;
      trig_s_q <= trig_m_q;
      err_m_q <= err_in;
      err_s_q <= err_m_q;
      match_m_q <= match_in;
      match_s_q <= match_m_q;
      trig_prev_q <= trig_s_q;
    end
  end
  wire logic hw_trig = trig_s_q & ~trig_prev_q;

  // ==========================================================
  // Register and channel state
  logic en_q, en_d, rpt_q, rpt_d, swreq_q, swreq_d, single_q, single_d, bsel_q, bsel_d;
  logic active_q, active_d, wait_q, wait_d, fault_q, fault_d, done_q, done_d;
  logic [1:0] flvl_q, flvl_d, dlvl_q, dlvl_d;
  dsc_pkg::dsc_ptr_ctl_t src_q, src_d, dst_q, dst_d;
  logic [7:0] count_q, count_d, left_q, left_d;
  logic beat_q, beat_d;
  dsc_pkg::dsc_state_t st_q, st_d;
  logic ack_q, ack_d, wreq_q, fault_irq_q, done_irq_q;
  logic [31:0] rdata_q, rdata_d;
  logic byte_req_q, byte_req_d;
  dsc_pkg::dsc_ptr_evt_t sevt_q, sevt_d, devt_q, devt_d;

  function automatic dsc_pkg::dsc_ptr_evt_t ptr_evt(input logic [1:0] rl, input logic [2:0] md,
      input logic byte_go, input logic burst_end, input logic block_end, input logic trans_end);
    dsc_pkg::dsc_ptr_evt_t e;
    e.step_now = byte_go & (md == `DSC_MODE_INC);
    e.reload_now = (rl == `DSC_RELOAD_BURST & burst_end) | (rl == `DSC_RELOAD_BLOCK & block_end)
                 | (rl == `DSC_RELOAD_TRANS & trans_end);
    return e;
  endfunction

  logic wr, rd, busy, trig_any, start, byte_go, burst_end, block_end, trans_end, abort, stop;
  always_comb begin
    wr = avs_write & ~ack_q;
    rd = avs_read & ~ack_q;
    busy = active_q;
    // software trigger only counts while enabled
    trig_any = en_q & (hw_trig | swreq_q);
    abort = en_q & wr & (avs_address == `DSC_IDX_MAIN) & ~avs_writedata[`DSC_MAIN_EN];
    start = 1'b0;
    byte_go = 1'b0;
    burst_end = 1'b0;
    block_end = 1'b0;
    trans_end = 1'b0;
    stop = 1'b0;
    st_d = st_q;
    left_d = left_q;
    beat_d = beat_q;
    case (st_q)
      dsc_pkg::DSC_IDLE: begin
        if (en_q) begin
          st_d = dsc_pkg::DSC_WAIT;
          left_d = count_q;
        end
      end
      dsc_pkg::DSC_WAIT, dsc_pkg::DSC_GAP: begin
        if (abort | ~en_q) begin
          st_d = dsc_pkg::DSC_IDLE;
        end else if (trig_any) begin
          start = 1'b1;
          st_d = dsc_pkg::DSC_BURST;
          beat_d = 1'b0;
        end
      end
      dsc_pkg::DSC_BURST: begin
        byte_go = 1'b1;
        left_d = left_q - 8'h01;
        beat_d = 1'b1;
        if (err_s_q) begin
          stop = 1'b1;
          st_d = dsc_pkg::DSC_IDLE;
        end else if (left_q == 8'h01 | match_s_q) begin
          burst_end = 1'b1;
          block_end = 1'b1;
          left_d = count_q;
          trans_end = ~rpt_q;
          st_d = rpt_q ? dsc_pkg::DSC_GAP : dsc_pkg::DSC_IDLE;
        end else if (~bsel_q | beat_q) begin
          // burst of one or two bytes ends here; continuous mode restarts it below
          burst_end = 1'b1;
          st_d = dsc_pkg::DSC_GAP;
        end
      end
      default: st_d = dsc_pkg::DSC_IDLE;
    endcase
    if (~single_q & burst_end & ~block_end & en_q & ~abort) begin
      st_d = dsc_pkg::DSC_BURST;
      beat_d = 1'b0;
    end
  end

  always_comb begin
    en_d = en_q;
    rpt_d = rpt_q;
    swreq_d = swreq_q;
    single_d = single_q;
    bsel_d = bsel_q;
    flvl_d = flvl_q;
    dlvl_d = dlvl_q;
    src_d = src_q;
    dst_d = dst_q;
    count_d = count_q;
    fault_d = fault_q;
    done_d = done_q;
    if (wr) begin
      case (avs_address)
        `DSC_IDX_MAIN: begin
          en_d = avs_writedata[`DSC_MAIN_EN];
          if (en_q) begin
            // request bit accepted only while enabled
            swreq_d = swreq_q | avs_writedata[`DSC_MAIN_SWREQ];
          end else begin
            // single-shot and repeat frozen while enabled
            rpt_d = avs_writedata[`DSC_MAIN_RPT];
            single_d = avs_writedata[`DSC_MAIN_SINGLE];
          end
          if (~busy) bsel_d = avs_writedata[`DSC_MAIN_BURST];
        end
        `DSC_IDX_STAT: begin
          flvl_d = avs_writedata[3:2];
          dlvl_d = avs_writedata[1:0];
          // fault flag cleared by writing one
          if (avs_writedata[`DSC_STAT_FAULT]) fault_d = 1'b0;
          // done flag cleared by writing one
          if (avs_writedata[`DSC_STAT_DONE]) done_d = 1'b0;
        end
        `DSC_IDX_SRC: begin
          if (~busy) src_d = {avs_writedata[5:4], avs_writedata[2:0]};
        end
        `DSC_IDX_DST: begin
          // frozen while busy; search codes kept
          if (~busy) dst_d = {avs_writedata[5:4], avs_writedata[2:0]};
        end
        `DSC_IDX_CNT: count_d = avs_writedata[7:0];
        default: ;
      endcase
    end
    // request bit clears as the transfer starts or the channel stops
    if (start | ~en_d | trans_end | stop) swreq_d = 1'b0;
    // enable clears at transaction end or on error
    if (trans_end | stop) en_d = 1'b0;
    // detected error sets the fault flag, winning over a clear
    if (stop) fault_d = 1'b1;
    // done after the block with repeat off; in repeat mode no block sets it
    if (trans_end) done_d = 1'b1;
    // active from start until disable, done or fault event
    active_d = active_q;
    if (start) active_d = 1'b1;
    // Events, not flag levels: an uncleared done flag must not hide a new transaction
    if (~en_d | trans_end | stop) active_d = 1'b0;
    // waiting while the first block after enable awaits its trigger; cleared on start or abort
    wait_d = en_d & (st_d == dsc_pkg::DSC_WAIT) & ~start;
  end

  // ==========================================================
  // Bus answer and outputs
  always_comb begin
    rdata_d = 32'h0;
    case (avs_address)
      `DSC_IDX_MAIN: rdata_d[7:0] = {en_q, 1'b0, rpt_q, swreq_q, 1'b0, single_q, 1'b0, bsel_q};
      `DSC_IDX_STAT: rdata_d[7:0] = {active_q, wait_q, fault_q, done_q, flvl_q, dlvl_q};
      `DSC_IDX_SRC: rdata_d[7:0] = {2'h0, src_q.reload, 1'b0, src_q.mode};
      `DSC_IDX_DST: rdata_d[7:0] = {2'h0, dst_q.reload, 1'b0, dst_q.mode};
      `DSC_IDX_CNT: rdata_d[7:0] = count_q;
      default: rdata_d = 32'h0;
    endcase
    ack_d = (rd | wr);
    byte_req_d = byte_go;
    sevt_d = ptr_evt(src_q.reload, src_q.mode, byte_go, burst_end, block_end, trans_end);
    devt_d = ptr_evt(dst_q.reload, dst_q.mode, byte_go, burst_end, block_end, trans_end);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_q <= 1'b0;
      rpt_q <= 1'b0;
      swreq_q <= 1'b0;
      single_q <= 1'b0;
      bsel_q <= 1'b0;
      active_q <= 1'b0;
      wait_q <= 1'b0;
      fault_q <= 1'b0;
      done_q <= 1'b0;
      flvl_q <= 2'h0;
      dlvl_q <= 2'h0;
      src_q <= '0;
      dst_q <= '0;
      count_q <= `DSC_RST_COUNT;
      left_q <= 8'h00;
      beat_q <= 1'b0;
      st_q <= dsc_pkg::DSC_IDLE;
      ack_q <= 1'b0;
      wreq_q <= 1'b1;
      fault_irq_q <= 1'b0;
      done_irq_q <= 1'b0;
      rdata_q <= 32'h0;
      byte_req_q <= 1'b0;
      sevt_q <= '0;
      devt_q <= '0;
    end else begin
      en_q <= en_d;
      rpt_q <= rpt_d;
      swreq_q <= swreq_d;
      single_q <= single_d;
      bsel_q <= bsel_d;
      active_q <= active_d;
      wait_q <= wait_d;
      fault_q <= fault_d;
      done_q <= done_d;
      flvl_q <= flvl_d;
      dlvl_q <= dlvl_d;
      src_q <= src_d;
      dst_q <= dst_d;
      count_q <= count_d;
      left_q <= left_d;
      beat_q <= beat_d;
      st_q <= st_d;
      ack_q <= ack_d;
      wreq_q <= ~ack_d;
      fault_irq_q <= fault_d & (flvl_d != 2'h0);
      done_irq_q <= done_d & (dlvl_d != 2'h0);
      rdata_q <= rdata_d;
      byte_req_q <= byte_req_d;
      sevt_q <= sevt_d;
      devt_q <= devt_d;
    end
  end

  assign avs_readdata = rdata_q;
  // Waitrequest stays high until the registered answer is ready
  assign avs_waitrequest = wreq_q;
  assign byte_req = byte_req_q;
  assign src_evt = sevt_q;
  assign dst_evt = devt_q;
  assign src_ctl = src_q;
  assign dst_ctl = dst_q;
  assign fault_irq = fault_irq_q;
  assign fault_irq_pri = flvl_q;
  assign done_irq = done_irq_q;
  assign done_irq_pri = dlvl_q;

  // ==========================================================
  // Checks
  a_fault_irq_gate: assert property (@(posedge clk) disable iff (rst)
    fault_irq == (fault_q && flvl_q != 2'h0)) else $error("fault request mismatch");
  a_done_set_irq: assert property (@(posedge clk) disable iff (rst)
    trans_end && dlvl_q != 2'h0 && !wr |=> done_irq) else $error("done request missing");
  a_fault_sticky: assert property (@(posedge clk) disable iff (rst)
    fault_q && !(wr && avs_address == `DSC_IDX_STAT && avs_writedata[5]) |=> fault_q)
    else $error("fault flag lost");
  a_done_sticky: assert property (@(posedge clk) disable iff (rst)
    done_q && !(wr && avs_address == `DSC_IDX_STAT && avs_writedata[4]) |=> done_q)
    else $error("done flag lost");
  a_active_start: assert property (@(posedge clk) disable iff (rst)
    start && !stop |=> active_q) else $error("active not set");
  a_active_clear: assert property (@(posedge clk) disable iff (rst)
    trans_end || stop || !en_q |=> !active_q) else $error("active not cleared");
  a_bsel_frozen: assert property (@(posedge clk) disable iff (rst)
    busy |=> bsel_q == $past(bsel_q)) else $error("burst select changed while busy");
  a_swreq_ignored: assert property (@(posedge clk) disable iff (rst)
    !en_q |=> !swreq_q) else $error("request taken while disabled");
  a_single_frozen: assert property (@(posedge clk) disable iff (rst)
    en_q |=> single_q == $past(single_q)) else $error("single changed while enabled");
  a_src_frozen: assert property (@(posedge clk) disable iff (rst)
    busy |=> src_q == $past(src_q)) else $error("source control changed while busy");
  a_wait_start: assert property (@(posedge clk) disable iff (rst)
    start |=> !wait_q) else $error("waiting flag not cleared");

endmodule

`default_nettype wire

//--- dsc_far_model.sv
// Far-side model: trigger source, error line and byte counter
`timescale 1ns/1ps
`default_nettype none

module dsc_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic byte_req,
  input wire logic fire,
  input wire logic err_arm,
  input wire logic clr,
  output logic trig_in,
  output logic err_in,
  output logic match_in,
  output logic [8:0] byte_cnt
);
  // ==========================================
  // Trigger and error lines
  logic [2:0] trig_q;
  // Trigger held three cycles so the two-flop sync cannot miss it
  assign trig_in = |trig_q;
  // Error is a level; a short pulse could fall between sampled bytes
  assign err_in = err_arm;
  // No search data in this model, so no match ever ends a block early
  assign match_in = 1'b0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_q <= 3'h0;
      byte_cnt <= 9'h000;
    end else begin
      trig_q <= fire ? 3'h7 : {trig_q[1:0], 1'b0};
      if (clr) begin
        byte_cnt <= 9'h000;
      end else if (byte_req) begin
        byte_cnt <= byte_cnt + 9'h001;
      end
    end
  end
endmodule
`default_nettype wire

//--- test_dsc_channel.sv
// Testbench for the channel control block
`timescale 1ns/1ps
`default_nettype none

module test_dsc_channel;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic trig_in, err_in, match_in, byte_req, fault_irq, done_irq;
  logic fire = 1'b0;
  logic err_arm = 1'b0;
  logic clr = 1'b0;
  logic [8:0] byte_cnt;
  logic [1:0] fault_irq_pri, done_irq_pri;
  dsc_pkg::dsc_ptr_evt_t src_evt, dst_evt;
  dsc_pkg::dsc_ptr_ctl_t src_ctl, dst_ctl;
  int n_fail = 0;
  int check_count = 0;
  logic [7:0] n_step = 8'h00;
  logic [7:0] n_reload = 8'h00;
  logic [2:0] modes [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};

  always #5 clk = ~clk;

  dsc_channel i_dsc_channel (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
    .err_in(err_in), .match_in(match_in), .byte_req(byte_req), .src_evt(src_evt),
    .dst_evt(dst_evt), .src_ctl(src_ctl), .dst_ctl(dst_ctl), .fault_irq(fault_irq),
    .fault_irq_pri(fault_irq_pri), .done_irq(done_irq), .done_irq_pri(done_irq_pri));

  dsc_far_model i_dsc_far_model (.clk(clk), .rst(rst), .byte_req(byte_req), .fire(fire),
    .err_arm(err_arm), .clr(clr), .trig_in(trig_in), .err_in(err_in),
    .match_in(match_in), .byte_cnt(byte_cnt));

  // Source pointer events as the address logic at the far side would see them
  always @(posedge clk) begin
    if (rst || clr) begin
      n_step <= 8'h00;
      n_reload <= 8'h00;
    end else begin
      n_step <= n_step + {7'h0, src_evt.step_now};
      n_reload <= n_reload + {7'h0, src_evt.reload_now};
    end
  end

  // ==========================================
  // Checks and bus tasks
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // Request held until the edge that sees waitrequest low; data taken there.
  // No local limit: a hung slave is caught by the watchdog.
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk(nm, e, q);
  endtask

  // Bounded wait for one of the two request lines
  task automatic wirq(input logic f);
    int n;
    n = 0;
    while ((f ? fault_irq : done_irq) !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk("irq wait", 8'h01, {7'h0, f ? fault_irq : done_irq});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    test_done;
  end

  // ==========================================
  // Tests
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rc(i[3:0], (i == 4) ? 8'h01 : 8'h00, "reset value");
    $display("test reset done");
    wr(4'h2, 8'hff);
    rc(4'h2, 8'h37, "src reserved");
    wr(4'h1, 8'hff);
    rc(4'h1, 8'h0f, "status ro");
    for (int i = 0; i < 5; i++) begin
      wr(4'h2, {2'h0, i[1:0], 3'h0, modes[i][0]});
      wr(4'h3, {2'h0, i[1:0], 1'b0, modes[i]});
      chk("src ctl", {3'h0, i[1:0], 2'h0, modes[i][0]}, {3'h0, src_ctl});
      chk("dst ctl", {3'h0, i[1:0], modes[i]}, {3'h0, dst_ctl});
    end
    $display("test fields done");
    wr(4'h2, 8'h11);
    wr(4'h4, 8'h10);
    clr <= 1'b1;
    wr(4'h0, 8'h80);
    clr <= 1'b0;
    rc(4'h1, 8'h4f, "waiting");
    wr(4'h0, 8'h90);
    rc(4'h1, 8'h8f, "active");
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h81);
    wirq(1'b0);
    chk("done pri", 8'h03, {6'h0, done_irq_pri});
    rc(4'h2, 8'h11, "src frozen");
    rc(4'h0, 8'h00, "main after block");
    rc(4'h1, 8'h1f, "done status");
    chk("bytes", 8'h10, byte_cnt[7:0]);
    chk("src steps", 8'h10, n_step);
    chk("src reloads", 8'h01, n_reload);
    wr(4'h1, 8'h0c);
    rc(4'h1, 8'h1c, "done kept");
    chk("done irq off", 8'h00, {7'h0, done_irq});
    wr(4'h1, 8'h1f);
    rc(4'h1, 8'h0f, "done cleared");
    $display("test block done");
    err_arm <= 1'b1;
    wr(4'h0, 8'h80);
    wr(4'h0, 8'h90);
    wirq(1'b1);
    err_arm <= 1'b0;
    chk("fault pri", 8'h03, {6'h0, fault_irq_pri});
    rc(4'h1, 8'h2f, "fault status");
    rc(4'h0, 8'h00, "main after fault");
    wr(4'h1, 8'h03);
    chk("fault irq off", 8'h00, {7'h0, fault_irq});
    wr(4'h1, 8'h2f);
    rc(4'h1, 8'h0f, "fault cleared");
    $display("test fault done");
    wr(4'h4, 8'h08);
    clr <= 1'b1;
    wr(4'h0, 8'h85);
    clr <= 1'b0;
    wr(4'h0, 8'h81);
    rc(4'h0, 8'h85, "single locked");
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (40) @(posedge clk);
    chk("single burst", 8'h02, byte_cnt[7:0]);
    wr(4'h0, 8'h04);
    rc(4'h0, 8'h05, "aborted");
    rc(4'h1, 8'h0f, "abort status");
    $display("test single done");
    clr <= 1'b1;
    wr(4'h0, 8'h10);
    clr <= 1'b0;
    repeat (20) @(posedge clk);
    rc(4'h0, 8'h00, "soft req off");
    chk("no bytes", 8'h00, byte_cnt[7:0]);
    $display("test soft request done");
    test_done;
  end
endmodule
`default_nettype wire
